// ==== hdl/dit_timers.v ====
/*
 * Two 16-bit interval timers with register port, port B line six/seven
 * logic, timer interrupt flags and enables.
 * Assumes a synchronous register master and synchronous pin inputs; the
 * clock stands in for the phase-2 system clock.
 */
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dit_regs.vh"

module dit_timers (
    input  wire       i_clk,
    input  wire       i_rst_n,
    input  wire [3:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    input  wire [7:0] i_port_b,
    output wire [7:0] o_port_b,
    output wire [7:0] o_port_b_oe,
    output wire       o_irq_n_out,
    output wire       o_irq_n_oe
);

    ////////////////////////////////////////////////////////////////////
    reg  [7:0]  port_b_output_latch;
    reg  [7:0]  port_b_direction;
    reg  [7:0]  auxiliary_control_bits;
    reg  [6:0]  irq_enable;
    reg  [15:0] t1_count;
    reg  [7:0]  t1_lat_lo;
    reg  [7:0]  t1_lat_hi;
    reg         t1_flag;
    reg         t1_armed;
    reg         t1_wave;
    reg  [15:0] t2_count;
    reg  [7:0]  t2_lat_lo;
    reg         t2_flag;
    reg         t2_armed;
    reg         pb6_prev;

    function hit;
        input [3:0] a;
        input [3:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire wr_t1_hi = i_wr & hit(i_addr, `DIT_OFS_T1_CNT_HI);
    wire wr_t2_hi = i_wr & hit(i_addr, `DIT_OFS_T2_CNT_HI);
    wire rd_t1_lo = i_rd & hit(i_addr, `DIT_OFS_T1_CNT_LO);
    wire rd_t2_lo = i_rd & hit(i_addr, `DIT_OFS_T2_LO);
    wire wr_flag  = i_wr & hit(i_addr, `DIT_OFS_IRQ_FLAG);

    wire t1_free  = auxiliary_control_bits[`DIT_AUX_T1_FREE];
    wire t1_out   = auxiliary_control_bits[`DIT_AUX_T1_OUT];
    wire t2_pulse = auxiliary_control_bits[`DIT_AUX_T2_PULSE];

    wire t1_zero  = (t1_count == `DIT_RST_WORD) & ~wr_t1_hi;
    // line six low at this edge, high at the last one
    wire pb6_fall = pb6_prev & ~i_port_b[`DIT_PB_PULSE];
    wire t2_step  = t2_pulse ? pb6_fall : 1'b1;
    // pulse mode: the counted pulse that brings the count to zero is the
    // zero event; interval mode sees zero one clock later, like timer one
    wire t2_hit   = t2_pulse ? (t2_count == `DIT_ONE_WORD) :
                               (t2_count == `DIT_RST_WORD);
    wire t2_zero  = t2_hit & t2_step & ~wr_t2_hi;

    ////////////////////////////////////////////////////////////////////
    // control and port registers
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_b_output_latch    <= `DIT_RST_BYTE;
            port_b_direction       <= `DIT_RST_BYTE;
            auxiliary_control_bits <= `DIT_RST_BYTE;
            irq_enable             <= 7'h00;
            pb6_prev               <= 1'b1;
        end else begin
            pb6_prev <= i_port_b[`DIT_PB_PULSE];
            if (i_wr) begin
                case (i_addr)
                    `DIT_OFS_PORTB_OUT: port_b_output_latch <= i_wdata;
                    `DIT_OFS_PORTB_DIR: port_b_direction <= i_wdata;
                    `DIT_OFS_AUX_CTRL:  auxiliary_control_bits <= i_wdata;
                    `DIT_OFS_IRQ_EN: begin
                        if (i_wdata[`DIT_EN_SET])
                            irq_enable <= irq_enable | i_wdata[6:0];
                        else
                            irq_enable <= irq_enable & ~i_wdata[6:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // first timer
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t1_count  <= `DIT_RST_WORD;
            t1_lat_lo <= `DIT_RST_BYTE;
            t1_lat_hi <= `DIT_RST_BYTE;
            t1_flag   <= 1'b0;
            t1_armed  <= 1'b0;
            t1_wave   <= 1'b1;
        end else begin
            if (i_wr && (hit(i_addr, `DIT_OFS_T1_CNT_LO) ||
                         hit(i_addr, `DIT_OFS_T1_LAT_LO)))
                t1_lat_lo <= i_wdata;
            if (i_wr && hit(i_addr, `DIT_OFS_T1_LAT_HI))
                t1_lat_hi <= i_wdata;
            if (wr_t1_hi) begin
                t1_lat_hi <= i_wdata;
                t1_count  <= {i_wdata, t1_lat_lo};
                t1_armed  <= 1'b1;
                // line seven goes low on load
                t1_wave   <= 1'b0;
            end else if (t1_zero && t1_free) begin
                t1_count <= {t1_lat_hi, t1_lat_lo};
                t1_wave  <= ~t1_wave;
            end else begin
                t1_count <= t1_count - `DIT_ONE_WORD;
                if (t1_zero && t1_armed) begin
                    t1_armed <= 1'b0;
                    t1_wave  <= 1'b1;
                end
            end
            // set wins over read and flag-register clears
            // set at zero
            if (t1_zero && (t1_free || t1_armed))
                t1_flag <= 1'b1;
            else if (wr_t1_hi || rd_t1_lo)
                t1_flag <= 1'b0;
            else if (wr_flag && i_wdata[`DIT_IRQ_T1])
                t1_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // second timer
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t2_count  <= `DIT_RST_WORD;
            t2_lat_lo <= `DIT_RST_BYTE;
            t2_flag   <= 1'b0;
            t2_armed  <= 1'b0;
        end else begin
            if (i_wr && hit(i_addr, `DIT_OFS_T2_LO))
                t2_lat_lo <= i_wdata;
            if (wr_t2_hi) begin
                t2_count <= {i_wdata, t2_lat_lo};
                t2_armed <= 1'b1;
            end else if (t2_step) begin
                t2_count <= t2_count - `DIT_ONE_WORD;
                if (t2_zero)
                    t2_armed <= 1'b0;
            end
            if (t2_zero && t2_armed)
                t2_flag <= 1'b1;
            else if (wr_t2_hi || rd_t2_lo)
                t2_flag <= 1'b0;
            else if (wr_flag && i_wdata[`DIT_IRQ_T2])
                t2_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pins and interrupt
    wire [6:0] flags = {t1_flag, t2_flag, 5'h00};
    wire       irq   = |(flags & irq_enable);

    // timer drives line seven only with both bits set
    wire pb7 = (port_b_direction[`DIT_PB_TIMER] & t1_out) ? t1_wave :
               port_b_output_latch[`DIT_PB_TIMER];
    assign o_port_b    = {pb7, port_b_output_latch[6:0]};
    assign o_port_b_oe = port_b_direction;
    // open-drain low while enabled flag set
    assign o_irq_n_out = 1'b0;
    assign o_irq_n_oe  = irq;

    ////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= `DIT_RST_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                `DIT_OFS_PORTB_OUT: o_rdata <= port_b_output_latch;
                `DIT_OFS_PORTB_DIR: o_rdata <= port_b_direction;
                `DIT_OFS_T1_CNT_LO: o_rdata <= t1_count[7:0];
                `DIT_OFS_T1_CNT_HI: o_rdata <= t1_count[15:8];
                `DIT_OFS_T1_LAT_LO: o_rdata <= t1_lat_lo;
                `DIT_OFS_T1_LAT_HI: o_rdata <= t1_lat_hi;
                `DIT_OFS_T2_LO:     o_rdata <= t2_count[7:0];
                `DIT_OFS_T2_CNT_HI: o_rdata <= t2_count[15:8];
                `DIT_OFS_AUX_CTRL:  o_rdata <= auxiliary_control_bits;
                `DIT_OFS_IRQ_FLAG:  o_rdata <= {irq, flags};
                `DIT_OFS_IRQ_EN:    o_rdata <= {1'b1, irq_enable};
                default:            o_rdata <= `DIT_RST_BYTE;
            endcase
        end else begin
            o_rdata <= `DIT_RST_BYTE;
        end
    end

endmodule // dit_timers
`default_nettype wire

// ==== hdl/dit_regs.vh ====
/*
 * Register map, field positions and reset values for the dual interval
 * timer block. Assumes a byte-wide register port with 4-bit addresses.
 */
// Overview of operation
// - control bits 7 and 6 both zero: first timer one-shot, no port output
// - low counter address write stores only the low reload latch
// - high counter write loads high latch and counter, copies low latch
// - first timer decrements from the next clock, once per clock
// - first timer reaching zero sets its interrupt flag
// - one-shot with output: line seven low after load, high at zero
// - reading low counter returns low byte and clears first timer flag
// - free-run: at zero set flag, invert line seven, reload sixteen bits
// - writing one to flag position clears the first timer flag
// - every high counter reload restarts the full time-out
// - latch-only writes leave the running countdown alone
// - low latch address writes like low counter, reads without clearing
// - high latch address stores high latch, no transfer, reads latch
// - reading high counter returns upper eight counter bits
// - line seven is timer output only if direction and control bit set
// - one control bit picks second timer interval or pulse counting
// - second timer: low latch, low counter, high counter, sixteen bits
// - second timer interval: flag once at zero, wrap, re-arm on reload
// - second timer high write loads byte, copies latch, clears flag
// - second timer low read returns count, clears flag; write stores latch
// - pulse mode decrements per low pulse on line six, flag once
// - interrupt request low when an enabled timer flag is set
`ifndef DIT_REGS_VH
`define DIT_REGS_VH

`define DIT_ADDR_W        4
`define DIT_OFS_PORTB_OUT 4'h0
`define DIT_OFS_PORTB_DIR 4'h2
`define DIT_OFS_T1_CNT_LO 4'h4
`define DIT_OFS_T1_CNT_HI 4'h5
`define DIT_OFS_T1_LAT_LO 4'h6
`define DIT_OFS_T1_LAT_HI 4'h7
`define DIT_OFS_T2_LO     4'h8
`define DIT_OFS_T2_CNT_HI 4'h9
`define DIT_OFS_AUX_CTRL  4'hB
`define DIT_OFS_IRQ_FLAG  4'hD
`define DIT_OFS_IRQ_EN    4'hE

`define DIT_AUX_T1_OUT    7
`define DIT_AUX_T1_FREE   6
`define DIT_AUX_T2_PULSE  5
`define DIT_IRQ_T1        6
`define DIT_IRQ_T2        5
`define DIT_IRQ_ANY       7
`define DIT_EN_SET        7
`define DIT_PB_TIMER      7
`define DIT_PB_PULSE      6

`define DIT_RST_BYTE      8'h00
`define DIT_RST_WORD      16'h0000
`define DIT_ONE_WORD      16'h0001
`define DIT_ALL_ONES      16'hFFFF

`endif

// ==== dv/dit_timers_assertions.sv ====
/* port checker for dit_timers; bound to every instance of it */
`timescale 1ns/1ps
`default_nettype none
module dit_chk (
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] i_port_b,
    input wire logic [7:0] o_port_b,
    input wire logic [7:0] o_port_b_oe,
    input wire logic       o_irq_n_out,
    input wire logic       o_irq_n_oe
);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
irq_pin_low_a: assert property (o_irq_n_out == 1'b0)
    else $error("irq drive value not low");
irq_mask_all_a: assert property (i_wr && i_addr == 4'hE
    && i_wdata == 8'h7F |=> !o_irq_n_oe) else $error("irq with no enable");
flag_any_bit_a: assert property (i_rd && i_addr == 4'hD
    |=> o_rdata[7] == $past(o_irq_n_oe)) else $error("flag bit7 not irq");
dir_to_oe_a: assert property (i_wr && i_addr == 4'h2
    |=> o_port_b_oe == $past(i_wdata)) else $error("direction not on oe");
// a read needs the gap cycle so no write can slip in between
hi_latch_rd_a: assert property (i_wr && i_addr == 4'h7 ##1 !i_wr
    ##1 i_rd && i_addr == 4'h7 |=> o_rdata == $past(i_wdata, 3))
    else $error("high latch readback");
lo_latch_rd_a: assert property (i_wr && (i_addr == 4'h4
    || i_addr == 4'h6) ##1 !i_wr ##1 i_rd && i_addr == 4'h6
    |=> o_rdata == $past(i_wdata, 3)) else $error("low latch readback");
count_step_a: assert property (i_rd && i_addr == 4'h4
    ##1 !i_wr && o_rdata > 8'h01 ##1 i_rd && i_addr == 4'h4
    |=> o_rdata == $past(o_rdata, 2) - 8'h02) else $error("count step");
rd_idle_zero_a: assert property (!$past(i_rd)
    |-> o_rdata == 8'h00) else $error("read data outside read slot");
endmodule // dit_chk
bind dit_timers dit_chk u_chk (.*);
`default_nettype wire

// ==== dv/dit_pulse_src.sv ====
/* pulse source on port B line six; other lines held low */
`timescale 1ns/1ps
`default_nettype none
module dit_pulse_src (
    input  wire logic       i_clk,
    output var  logic [7:0] o_port_b = 8'h40
);
task automatic pulse(input int n);
    repeat (n) begin
        @(posedge i_clk) o_port_b[6] <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_port_b[6] <= 1'b1;
        repeat (2) @(posedge i_clk);
    end
endtask
endmodule // dit_pulse_src
`default_nettype wire

// ==== dv/tb.sv ====
/* bench for dit_timers; pulse model drives the port B inputs */
`timescale 1ns/1ps
`default_nettype none
module tb;
logic       clk, rst_n, wr, rd, irq_out, irq_oe;
logic [3:0] addr;
logic [7:0] wdata, rdata, pb_in, pb, pb_oe, rv;
int         n_errors = 0, total_checks = 0, n;
dit_timers u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_port_b(pb_in), .o_port_b(pb), .o_port_b_oe(pb_oe),
    .o_irq_n_out(irq_out), .o_irq_n_oe(irq_oe));
dit_pulse_src u_src (.i_clk(clk), .o_port_b(pb_in));
initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
        n_errors++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task automatic w(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
endtask
// masked compare: some flag bits belong to other scenarios
task automatic r(input logic [3:0] a, input logic [7:0] e, m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
    chk(rv & m, e);
endtask
task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
endtask
task automatic tog();
    logic p;
    p = pb[7];
    n = 0;
    while (pb[7] === p && n < 100) begin
        idle(1);
        n = n + 1;
    end
endtask
task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
// tests need well under a thousand cycles
initial begin
    #20000 n_errors++;
    wrap_up();
end
initial begin
    {rst_n, wr, rd, addr, wdata} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    w(4'hF, 8'h5A);
    r(4'hF, 8'h00, 8'hFF);
    w(4'h7, 8'hAB);
    r(4'h7, 8'hAB, 8'hFF);
    w(4'h4, 8'h5C);
    r(4'h6, 8'h5C, 8'hFF);
    w(4'h2, 8'h80);
    chk(pb[7], 1'b0);
    w(4'hE, 8'hE0);
    w(4'hB, 8'h80);
    chk(pb[7], 1'b1);
    w(4'h6, 8'h10);
    w(4'h5, 8'h00);
    chk(pb[7], 1'b0);
    r(4'h4, 8'h0F, 8'hFF);
    r(4'h4, 8'h0D, 8'hFF);
    r(4'h5, 8'h00, 8'hFF);
    idle(20);
    chk({pb[7], irq_oe}, 2'h3);
    r(4'h6, 8'h10, 8'hFF);
    r(4'hD, 8'hC0, 8'hFF);
    r(4'h4, 8'h00, 8'h00);
    r(4'hD, 8'h00, 8'hFF);
    w(4'h5, 8'h00);
    idle(20);
    w(4'hD, 8'h40);
    r(4'hD, 8'h00, 8'hFF);
    repeat (6) begin
        w(4'h5, 8'h00);
        idle(8);
    end
    chk({pb[7], irq_oe}, 2'h0);
    w(4'hB, 8'hC0);
    w(4'h6, 8'h08);
    w(4'h5, 8'h00);
    tog();
    tog();
    chk(n, 9);
    w(4'h6, 8'h10);
    tog();
    tog();
    chk(n, 17);
    r(4'hD, 8'hC0, 8'hFF);
    w(4'hE, 8'h40);
    w(4'hB, 8'h00);
    w(4'h8, 8'h05);
    w(4'h9, 8'h00);
    idle(12);
    r(4'hD, 8'hA0, 8'hA0);
    chk(irq_oe, 1'b1);
    r(4'h9, 8'hFF, 8'hFF);
    r(4'h8, 8'h00, 8'h00);
    r(4'hD, 8'h00, 8'hA0);
    w(4'h9, 8'h00);
    idle(12);
    w(4'h9, 8'h00);
    r(4'hD, 8'h00, 8'hA0);
    w(4'hB, 8'h20);
    w(4'h8, 8'h03);
    w(4'h9, 8'h00);
    u_src.pulse(2);
    r(4'h8, 8'h01, 8'hFF);
    u_src.pulse(1);
    r(4'hD, 8'hA0, 8'hA0);
    r(4'h8, 8'h00, 8'hFF);
    u_src.pulse(1);
    r(4'hD, 8'h00, 8'hA0);
    r(4'h9, 8'hFF, 8'hFF);
    w(4'hE, 8'h7F);
    chk(irq_oe, 1'b0);
    idle(2);
    wrap_up();
end
endmodule // tb
`default_nettype wire
